/* File: inc/can_fc_consts.vh */
// Purpose: constants for the CAN fault-confinement status block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CAN_FC_CONSTS_VH
`define CAN_FC_CONSTS_VH
// Communication state codes
`define ST_ERR_ACTIVE   2'h0
`define ST_ERR_PASSIVE  2'h1
`define ST_BUS_OFF      2'h2
`define ST_INIT         2'h3
// Last error codes
`define LE_NONE   3'h0
`define LE_STUFF  3'h1
`define LE_FORM   3'h2
`define LE_ACK    3'h3
`define LE_BIT1   3'h4
`define LE_BIT0   3'h5
`define LE_CRC    3'h6
// Error kind codes on the event port
`define EK_STUFF  3'h1
`define EK_FORM   3'h2
`define EK_ACK    3'h3
`define EK_BIT1   3'h4
`define EK_BIT0   3'h5
`define EK_CRC    3'h6
// Counter thresholds and weights
`define PASSIVE_LIMIT  9'h080
`define BUSOFF_LIMIT   9'h100
`define ERR_STEP       9'h008
`define OK_STEP        9'h001
// Register offsets
`define REG_CTRL    4'h0
`define REG_STATUS  4'h1
`define REG_COUNT   4'h2
`define REG_FAULT   4'h3
// Control register fields
`define CTRL_START_BIT   0
`define CTRL_STOP_BIT    1
`define CTRL_SLEEP_BIT   2
`define CTRL_LOGERR_BIT  3
// Status register fields
`define STAT_STATE_LSB   0
`define STAT_LAST_LSB    4
`define STAT_XCVR_BIT    8
`define STAT_SLEEP_BIT   9
`define STAT_FAULT_BIT   10
`define STAT_TXVAL_BIT   11
`define CTRL_RESET       32'h00000000
`endif

/* File: src/can_error_confinement_status.v */
// Purpose: fault confinement state, error counters and status of a CAN node
// Assumes: protocol engine reports per-frame events synchronous to core_clk
// Notes:   registers on a plain strobe port, read data one cycle later
//
// Operation
// - Code 0 while both counters below 128
// - Counter above 127 gives error passive, code 1
// - No transmit increment for ack errors when passive
// - Transmit counter above 255: bus off, traffic stops
// - Bus off held until explicit restart
// - Power-up in initial state, code 3, silent
// - Start trigger moves initial to error active
// - Stop returns active or passive to initial
// - Transceiver error flag follows fault pin
// - Sleep flag shows controller asleep
// - Last error 0 after success
// - Last error 1 on stuffing violation
// - Last error 2 on form error
// - Last error 3 on missing acknowledge
// - Unacknowledged frames retried without limit
// - Last error 4 on recessive sent, dominant seen
// - Last error 5 on dominant sent, recessive seen
// - Last error 6 on CRC mismatch
// - Eight-bit receive counter, reset at start
// - Transmit counter, errors weigh more than successes
// - Transmit counter invalid after bus off
// - Fault flag and code, code zero when clear
// - Optional logging of bus errors as frames
`timescale 1ns/1ps
`include "can_fc_consts.vh"

module can_error_confinement_status #(
    parameter FAULT_W = 16
) (
    // Clock and reset
    input  wire                core_clk,
    input  wire                reset_n,
    // Register port
    input  wire [3:0]          reg_addr,
    input  wire [31:0]         reg_wdata,
    input  wire                reg_wr,
    input  wire                reg_rd,
    output reg  [31:0]         reg_rdata,
    // Frame events from the protocol engine
    input  wire                rx_ok,
    input  wire                tx_ok,
    input  wire                rx_err,
    input  wire                tx_err,
    input  wire [2:0]          err_kind,
    // Transceiver and fault inputs
    input  wire                transceiver_fault_pin,
    input  wire                sleep_ack,
    input  wire                fault_in,
    input  wire [FAULT_W-1:0]  fault_code_in,
    // Engine control and error frame log
    output wire                comm_enable,
    output wire                tx_retry,
    output wire                sleep_req,
    output reg                 err_frame_valid,
    output reg  [2:0]          err_frame_code,
    output reg                 err_frame_is_tx
);

    ////////////////////////////////////////////////////////////////////////
    reg  [1:0]          comm_state;
    reg  [7:0]          rx_count;
    reg  [8:0]          tx_count;
    reg  [2:0]          last_error;
    reg                 tx_count_valid;
    reg                 xcvr_err;
    reg                 sleep_flag;
    reg                 fault_flag;
    reg  [FAULT_W-1:0]  fault_code;
    reg                 ctrl_sleep;
    reg                 ctrl_log;
    reg  [1:0]          next_state;
    reg  [7:0]          next_rx;
    reg  [8:0]          next_tx;

    // Full-width copies so the receive path can take an 8-bit slice on purpose
    localparam [8:0] ERR_STEP_W = `ERR_STEP;
    localparam [8:0] OK_STEP_W  = `OK_STEP;

    wire start_cmd = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_START_BIT];
    wire stop_cmd  = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_STOP_BIT];
    wire running   = (comm_state == `ST_ERR_ACTIVE) || (comm_state == `ST_ERR_PASSIVE);

    // Map an error kind to its last-error code
    function [2:0] kind_to_code;
        input [2:0] kind;
        begin
            case (kind)
                `EK_STUFF: kind_to_code = `LE_STUFF;
                `EK_FORM:  kind_to_code = `LE_FORM;
                `EK_ACK:   kind_to_code = `LE_ACK;
                `EK_BIT1:  kind_to_code = `LE_BIT1;
                `EK_BIT0:  kind_to_code = `LE_BIT0;
                `EK_CRC:   kind_to_code = `LE_CRC;
                default:   kind_to_code = `LE_FORM;
            endcase
        end
    endfunction

    // Engine only runs in the two communicating states
    assign comm_enable = running;
    // Retry never stops on its own; only bus off or stop ends it
    assign tx_retry    = running && tx_err;
    assign sleep_req   = ctrl_sleep;

    ////////////////////////////////////////////////////////////////////////
    // Counter arithmetic, saturating at top and floored at zero
    always @* begin
        next_rx = rx_count;
        next_tx = tx_count;
        if (running) begin
            if (rx_err) begin
                if (rx_count > 8'hf7)
                    next_rx = 8'hff;
                else
                    next_rx = rx_count + ERR_STEP_W[7:0];
            end else if (rx_ok && rx_count != 8'h00) begin
                next_rx = rx_count - OK_STEP_W[7:0];
            end
            // Passive node ignores ack errors so a lone sender stays alive
            if (tx_err && !(comm_state == `ST_ERR_PASSIVE && err_kind == `EK_ACK)) begin
                if (tx_count >= `BUSOFF_LIMIT)
                    next_tx = tx_count;
                else
                    next_tx = tx_count + `ERR_STEP;
            end else if (tx_ok && tx_count != 9'h000) begin
                next_tx = tx_count - `OK_STEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State decision from command and next counter values
    always @* begin
        next_state = comm_state;
        case (comm_state)
            `ST_INIT: begin
                if (start_cmd)
                    next_state = `ST_ERR_ACTIVE;
            end
            `ST_ERR_ACTIVE, `ST_ERR_PASSIVE: begin
                if (stop_cmd)
                    next_state = `ST_INIT;
                else if (next_tx >= `BUSOFF_LIMIT)
                    next_state = `ST_BUS_OFF;
                else if ({1'b0, next_rx} >= `PASSIVE_LIMIT || next_tx >= `PASSIVE_LIMIT)
                    next_state = `ST_ERR_PASSIVE;
                else
                    next_state = `ST_ERR_ACTIVE;
            end
            `ST_BUS_OFF: begin
                if (start_cmd)
                    next_state = `ST_ERR_ACTIVE;
            end
            default: next_state = `ST_INIT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State, counters and last error
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            comm_state     <= `ST_INIT;
            rx_count       <= 8'h00;
            tx_count       <= 9'h000;
            tx_count_valid <= 1'b0;
            last_error     <= `LE_NONE;
        end else begin
            comm_state <= next_state;
            if (start_cmd && (comm_state == `ST_INIT || comm_state == `ST_BUS_OFF)) begin
                rx_count       <= 8'h00;
                tx_count       <= 9'h000;
                tx_count_valid <= 1'b1;
                last_error     <= `LE_NONE;
            end else begin
                rx_count <= next_rx;
                tx_count <= next_tx;
                if (next_state == `ST_BUS_OFF)
                    tx_count_valid <= 1'b0;
                if (running) begin
                    if (rx_err || tx_err)
                        last_error <= kind_to_code(err_kind);
                    else if (rx_ok || tx_ok)
                        last_error <= `LE_NONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transceiver, sleep and fault flags
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            xcvr_err   <= 1'b0;
            sleep_flag <= 1'b0;
            fault_flag <= 1'b0;
            fault_code <= {FAULT_W{1'b0}};
        end else begin
            xcvr_err   <= transceiver_fault_pin;
            sleep_flag <= sleep_ack;
            fault_flag <= fault_in;
            // Code forced to zero whenever no fault is shown
            fault_code <= fault_in ? fault_code_in : {FAULT_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and bus error frame log
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_sleep      <= 1'b0;
            ctrl_log        <= 1'b0;
            err_frame_valid <= 1'b0;
            err_frame_code  <= `LE_NONE;
            err_frame_is_tx <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL) begin
                ctrl_sleep <= reg_wdata[`CTRL_SLEEP_BIT];
                ctrl_log   <= reg_wdata[`CTRL_LOGERR_BIT];
            end
            // One pulse per detected bus error, only when logging is on
            err_frame_valid <= ctrl_log && running && (rx_err || tx_err);
            if (running && (rx_err || tx_err)) begin
                err_frame_code  <= kind_to_code(err_kind);
                err_frame_is_tx <= tx_err;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:
                    reg_rdata <= {28'h0000000, ctrl_log, ctrl_sleep, 2'h0};
                `REG_STATUS:
                    reg_rdata <= {20'h00000, tx_count_valid, fault_flag, sleep_flag, xcvr_err,
                                  1'b0, last_error, 2'h0, comm_state};
                `REG_COUNT:
                    // Transmit count reads zero while invalid
                    reg_rdata <= {7'h00, (tx_count_valid ? tx_count : 9'h000), 8'h00, rx_count};
                `REG_FAULT:
                    reg_rdata <= {{(32-FAULT_W){1'b0}}, fault_code};
                default:
                    reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

/* File: test/can_fc_asserts.sv */
// Purpose: port assertions for the fault confinement block
// Assumes: one clock, reset_n asynchronous active low
// Notes:   attached by bind at the foot
`timescale 1ns/1ps
module can_fc_asserts (
    // Clock and reset
    input logic        core_clk,
    input logic        reset_n,
    // Register port
    input logic [3:0]  reg_addr,
    input logic [31:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [31:0] reg_rdata,
    // Events and fault
    input logic        rx_err,
    input logic        tx_err,
    input logic [2:0]  err_kind,
    input logic        fault_in,
    // Engine control and log
    input logic        comm_enable,
    input logic        tx_retry,
    input logic        err_frame_valid,
    input logic [2:0]  err_frame_code,
    input logic        err_frame_is_tx
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    // Traffic resumes only through a start write
    start_only_a: assert property ($rose(comm_enable) |-> $past(reg_wr && reg_addr == 4'h0 && reg_wdata[0]))
        else $error("traffic enabled without start");
    stop_a: assert property (comm_enable && reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h2 |=> !comm_enable)
        else $error("stop ignored");
    // A drop without stop means bus off, so a transmit error must precede
    bus_off_a: assert property (
        $fell(comm_enable) |-> $past(tx_err) || $past(reg_wr && reg_addr == 4'h0 && reg_wdata[1]))
        else $error("traffic stopped without cause");
    retry_a: assert property (tx_err && comm_enable |-> tx_retry)
        else $error("no retry after transmit error");
    silent_a: assert property (!comm_enable |-> !tx_retry ##1 !err_frame_valid)
        else $error("activity while not communicating");
    log_cause_a: assert property (err_frame_valid |-> $past((rx_err || tx_err) && comm_enable))
        else $error("error frame without error");
    log_code_a: assert property (
        err_frame_valid |-> err_frame_code == $past(err_kind) && err_frame_is_tx == $past(tx_err))
        else $error("error frame content wrong");
    // Flag lags one cycle, so demand a quiet history before the read
    fault_zero_a: assert property (
        $past(reg_rd && reg_addr == 4'h3) && !$past(fault_in) && !$past(fault_in, 2) |-> reg_rdata == 32'h0)
        else $error("fault code without fault");
endmodule
////////////////////////////////////////////////////////////
bind can_error_confinement_status can_fc_asserts chk (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rx_err, .tx_err, .err_kind, .fault_in, .comm_enable, .tx_retry, .err_frame_valid,
    .err_frame_code, .err_frame_is_tx);

/* File: test/can_peer_model.sv */
// Purpose: far-side nodes as seen through the protocol engine
// Assumes: events are one-cycle pulses taken at the rising edge
// Notes:   never acknowledges unless told, kind scrambled when idle
`timescale 1ns/1ps
module can_peer_model (
    // Clock
    input  logic       core_clk,
    // Frame events
    output logic       rx_ok,
    output logic       tx_ok,
    output logic       rx_err,
    output logic       tx_err,
    output logic [2:0] err_kind
);
    initial {tx_err, rx_err, tx_ok, rx_ok, err_kind} = 7'h0;
    // One event; kind inverted afterwards so a stale value never helps
    task send(input logic [1:0] ev, input logic [2:0] k);
        @(posedge core_clk);
        {tx_err, rx_err, tx_ok, rx_ok} <= 4'h1 << ev;
        err_kind <= k;
        @(posedge core_clk);
        {tx_err, rx_err, tx_ok, rx_ok} <= 4'h0;
        err_kind <= ~k;
    endtask
endmodule

/* File: test/can_error_confinement_status_tb.sv */
// Purpose: self-checking bench for the fault confinement block
// Assumes: peer model drives events, bench drives registers
// Notes:   read data checked mid-cycle against a queue
`timescale 1ns/1ps
module can_error_confinement_status_tb;
    logic        core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, pend = 0;
    logic        xcvr_fault = 0, sleep_ack = 0, fault_in = 0, rx_ok, tx_ok, rx_err, tx_err, comm_enable, sleep_req;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, exp_q[$], msk_q[$];
    logic [15:0] fault_code_in = 16'h0;
    logic [8:0]  tx = 9'h0;
    logic [7:0]  rx = 8'h0;
    logic [2:0]  err_kind, le = 3'h0;
    logic [1:0]  st = 2'h3;
    int          errors = 0, tests_run = 0, i;
    always #5 core_clk = ~core_clk;
    can_error_confinement_status dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_ok, .tx_ok, .rx_err, .tx_err, .err_kind, .transceiver_fault_pin(xcvr_fault), .sleep_ack, .fault_in,
        .fault_code_in, .comm_enable, .tx_retry(), .sleep_req, .err_frame_valid(), .err_frame_code(),
        .err_frame_is_tx());
    can_peer_model peer (.core_clk, .rx_ok, .tx_ok, .rx_err, .tx_err, .err_kind);
    ////////////////////////////////////////////////////////////
    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
    endtask
    task status(input logic [31:0] m);
        rd(4'h1, {20'h0, st != 2'h2, fault_in, sleep_ack, xcvr_fault, 1'b0, le, 2'h0, st}, m);
    endtask
    task counts;
        rd(4'h2, {7'h0, st == 2'h2 ? 9'h0 : tx, 8'h0, rx}, 32'hffffffff);
    endtask
    // Event plus reference model; refused outside active and passive
    task ev(input logic [1:0] e, input logic [2:0] k);
        peer.send(e, k);
        if (st[1] == 1'b0) begin
            le = e[1] ? k : 3'h0;
            if (e == 2'h0 && rx != 0) rx = rx - 8'h1;
            if (e == 2'h1 && tx != 0) tx = tx - 9'h1;
            if (e == 2'h2) rx = (rx > 8'd247) ? 8'hff : rx + 8'h8;
            if (e == 2'h3 && !(st == 2'h1 && k == 3'h3)) tx = tx + 9'h8;
            st = tx > 9'd255 ? 2'h2 : (rx > 8'd127 || tx > 9'd127) ? 2'h1 : 2'h0;
        end
    endtask
    task conclude;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Read data stand one cycle only; sample mid-cycle to avoid the edge
    always @(posedge core_clk) pend <= reg_rd;
    always @(negedge core_clk) if (pend) cmp("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        conclude;
    end
    initial begin
        i = $urandom(14976);
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        status(32'h7ff);
        rd(4'h7, 32'h0, 32'hffffffff);
        wr(4'h0, 32'hd);
        st = 2'h0;
        status(32'hfff);
        rd(4'h0, 32'hc, 32'hffffffff);
        cmp("sleep_req", 32'h1, {31'h0, sleep_req});
        counts;
        for (i = 1; i < 7; i++) begin
            ev(i[0] ? 2'h3 : 2'h2, i[2:0]);
            status(32'hfff);
        end
        ev(2'h0, 3'h0);
        status(32'hfff);
        counts;
        while (st == 2'h0) ev(2'h2, 3'h6);
        status(32'hfff);
        repeat (3) ev(2'h3, 3'h3);
        counts;
        while (st != 2'h2) ev(2'h3, 3'h4 + 3'($urandom % 2));
        status(32'hfff);
        ev(2'h2, 3'h1);
        wr(4'h0, 32'h2);
        status(32'hfff);
        counts;
        wr(4'h0, 32'hd);
        {st, rx, tx} = 19'h0;
        le = 3'h0;
        status(32'hfff);
        ev(2'h1, 3'h0);
        counts;
        wr(4'h0, 32'h2);
        st = 2'h3;
        status(32'h7ff);
        repeat (2) begin
            @(posedge core_clk);
            xcvr_fault    <= 1'($urandom);
            sleep_ack     <= 1'($urandom);
            fault_in      <= ~fault_in;
            fault_code_in <= 16'($urandom);
            repeat (2) @(posedge core_clk);
            status(32'h7ff);
            rd(4'h3, fault_in ? {16'h0, fault_code_in} : 32'h0, 32'hffffffff);
        end
        repeat (3) @(posedge core_clk);
        conclude;
    end
endmodule
